// ### one_second_alarm_monitor.sv
// One-second occurrence and persistence flags behind a Wishbone slave
`timescale 1ns/1ps

// Notes on behaviour
// R01 - Bit 7 reports signal loss
// R02 - Bit 6 reports alarm indication signal
// R03 - Bit 5 reports out of frame
// R04 - Bit 4 reports remote alarm
// R05 - Bit 3 reports frame alignment change
// R06 - Bit 2 reports multiframe alignment lost
// R07 - Bit 1 reports transmit buffer slip
// R08 - Bit 0 reports receive buffer slip
// R09 - Persisting means active, not risen last interval
// R10 - Outside supplies the periodic one-second tick
// R11 - Flags produced only while monitor enable set
// R12 - Tick rising edge marks interval boundary
// R13 - Slip active for 125 us after slip
// R14 - Results held stable until next boundary
module one_second_alarm_monitor
  import alarm_mon_pkg::*;
#(
  parameter int ADR_W = 12
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  // Conditions from the framer
  input  wire alarm_lv_t         alarm_i,
  input  wire slip_ev_t          slip_i,
  // Interval pin
  input  wire logic              one_second_tick_i,
  // Interrupt
  output      logic              irq_o
);

  if (ADR_W < 12 || ADR_W > 32) begin : gen_adr_check
    $error("ADR_W must lie between 12 and 32");
  end

  localparam int SLIP_CW = $clog2(SLIP_HOLD_CYC + 1);
  localparam logic [SLIP_CW-1:0] SLIP_LOAD = SLIP_CW'(SLIP_HOLD_CYC);
  localparam logic [SLIP_CW-1:0] SLIP_ZERO = '0;
  localparam logic [SLIP_CW-1:0] SLIP_ONE  = SLIP_CW'(1);

  logic [7:0]       global_cfg;
  logic [7:0]       occ_flags;
  logic [7:0]       pers_flags;
  logic [7:0]       seen_acc;
  logic [7:0]       rose_acc;
  logic [7:0]       cond;
  logic [7:0]       cond_q;
  logic [7:0]       rise;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [SLIP_CW-1:0] slip_cnt [2];
  logic [1:0]       slip_act;
  logic             tick_meta;
  logic             tick_sync;
  logic             tick_q;
  logic             boundary;
  logic             pm_en;
  logic             bus_req;
  logic             bus_wr;
  logic [9:0]       bus_idx;

  // Register index from an aligned byte address
  function automatic logic [9:0] word_index(input logic [ADR_W-1:0] adr);
    logic [ADR_W-3:0] w;
    w = adr[ADR_W-1:2];
    return 10'(w);
  endfunction : word_index

  assign pm_en = global_cfg[CFG_PM_EN_BIT];

  // R10 tick from outside
  // R12 two-stage synchroniser
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_q    <= 1'b0;
    end else begin
      tick_meta <= one_second_tick_i;
      tick_sync <= tick_meta;
      tick_q    <= tick_sync;
    end
  end

  // R12 rising edge boundary
  assign boundary = tick_sync & ~tick_q;

  // R13 slip hold counters
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slip_cnt[0] <= SLIP_ZERO;
      slip_cnt[1] <= SLIP_ZERO;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (slip_i[i]) begin
          slip_cnt[i] <= SLIP_LOAD;
        end else if (slip_cnt[i] != SLIP_ZERO) begin
          slip_cnt[i] <= slip_cnt[i] - 1'b1;
        end
      end
    end
  end

  assign slip_act[0] = slip_cnt[0] != SLIP_ZERO;
  assign slip_act[1] = slip_cnt[1] != SLIP_ZERO;

  // R01 to R08 place each condition
  always_comb begin
    cond              = 8'h00;
    cond[BIT_LOS]     = alarm_i.signal_loss;
    cond[BIT_AIS]     = alarm_i.alarm_signal;
    cond[BIT_OOF]     = alarm_i.frame_loss;
    cond[BIT_RAI]     = alarm_i.remote_alarm;
    cond[BIT_REALIGN] = alarm_i.frame_alignment_change;
    cond[BIT_MF_LOSS] = alarm_i.multiframe_alignment_lost;
    cond[BIT_TX_SLIP] = slip_act[1];
    cond[BIT_RX_SLIP] = slip_act[0];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cond_q <= FLAGS_RESET;
    end else begin
      cond_q <= cond;
    end
  end

  assign rise = cond & ~cond_q;

  // R14 accumulate the running interval
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_acc <= FLAGS_RESET;
      rose_acc <= FLAGS_RESET;
    end else if (!pm_en || boundary) begin
      seen_acc <= FLAGS_RESET;
      rose_acc <= FLAGS_RESET;
    end else begin
      seen_acc <= seen_acc | cond;
      rose_acc <= rose_acc | rise;
    end
  end

  // R11 capture only while enabled
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      occ_flags  <= FLAGS_RESET;
      pers_flags <= FLAGS_RESET;
    end else if (!pm_en) begin
      occ_flags  <= FLAGS_RESET;
      pers_flags <= FLAGS_RESET;
    end else if (boundary) begin
      occ_flags  <= seen_acc | cond;
      // R09 active but not risen
      pers_flags <= cond & ~(rose_acc | rise);
    end
  end

  // Bus request decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx = word_index(wb_adr_i);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // R11 enable lives in global config
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      global_cfg <= CFG_RESET;
      irq_mask   <= IRQ_RESET;
    end else if (bus_wr) begin
      if (bus_idx == IDX_GLOBAL_CFG) begin
        global_cfg <= wb_dat_i[7:0];
      end
      if (bus_idx == IDX_IRQ_MASK) begin
        irq_mask <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // Read data; unmapped words read zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      unique case (bus_idx)
        IDX_GLOBAL_CFG: wb_dat_o <= {24'h00_0000, global_cfg};
        IDX_OCCURRENCE: wb_dat_o <= {24'h00_0000, occ_flags};
        IDX_PERSISTENT: wb_dat_o <= {24'h00_0000, pers_flags};
        IDX_IRQ_STATUS: wb_dat_o <= {30'h0000_0000, irq_status};
        IDX_IRQ_MASK:   wb_dat_o <= {30'h0000_0000, irq_mask};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt events and write-one-to-clear
  assign irq_event[IRQ_BOUNDARY] = boundary & pm_en;
  assign irq_event[IRQ_ANY_SEEN] = boundary & pm_en & |(seen_acc | cond);
  assign irq_clear = (bus_wr && bus_idx == IDX_IRQ_STATUS) ?
                     wb_dat_i[IRQ_W-1:0] : IRQ_RESET;
  // A new event wins over a clear in the same cycle
  assign next_irq_status = (irq_status & ~irq_clear) | irq_event;
  // Mask as it stands after this edge, so the level follows a mask write at once
  assign next_irq_mask = (bus_wr && bus_idx == IDX_IRQ_MASK) ?
                         wb_dat_i[IRQ_W-1:0] : irq_mask;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status <= IRQ_RESET;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_o      <= |(next_irq_status & next_irq_mask);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence cap_s;
    boundary && pm_en;
  endsequence

  sequence tick_rise_s;
    $rose(one_second_tick_i) && pm_en;
  endsequence

  property bit_seen_p(int b);
    cap_s ##0 cond[b] |=> occ_flags[b];
  endproperty

  property bit_idle_p(int b);
    cap_s ##0 !cond[b] ##0 !seen_acc[b] |=> !occ_flags[b] && !pers_flags[b];
  endproperty

  los_flag_a: assert property (bit_seen_p(BIT_LOS)) // R01
    else $error("signal loss not captured at bit 7");
  ais_flag_a: assert property (bit_seen_p(BIT_AIS)) // R02
    else $error("alarm signal not captured at bit 6");
  oof_flag_a: assert property (bit_seen_p(BIT_OOF)) // R03
    else $error("frame loss not captured at bit 5");
  rai_flag_a: assert property (bit_seen_p(BIT_RAI)) // R04
    else $error("remote alarm not captured at bit 4");
  realign_flag_a: assert property (bit_seen_p(BIT_REALIGN)) // R05
    else $error("realign not captured at bit 3");
  mf_loss_flag_a: assert property (bit_idle_p(BIT_MF_LOSS)) // R06
    else $error("multiframe bit set without cause");
  tx_slip_flag_a: assert property (bit_seen_p(BIT_TX_SLIP)) // R07
    else $error("transmit slip not captured at bit 1");
  rx_slip_flag_a: assert property (bit_idle_p(BIT_RX_SLIP)) // R08
    else $error("receive slip bit set without cause");
  mf_loss_seen_a: assert property (bit_seen_p(BIT_MF_LOSS)) // R06
    else $error("multiframe loss not captured at bit 2");
  rx_slip_seen_a: assert property (bit_seen_p(BIT_RX_SLIP)) // R08
    else $error("receive slip not captured at bit 0");

  persist_rule_a: assert property ( // R09
    cap_s |=> (pers_flags & ~$past(cond)) == 8'h00
           && (pers_flags & $past(rose_acc)) == 8'h00)
    else $error("persistence flag set for new or idle condition");

  pers_subset_a: assert property ( // R09
    cap_s |=> (pers_flags & ~occ_flags) == 8'h00)
    else $error("persisting condition missing from occurrence flags");

  occ_cause_a: assert property ( // R14
    cap_s |=> (occ_flags & ~$past(seen_acc | cond)) == 8'h00)
    else $error("occurrence flag set without cause");

  enable_gate_a: assert property (!pm_en |=> occ_flags == 8'h00 // R11
                                         && pers_flags == 8'h00)
    else $error("flags present while monitor disabled");

  disabled_events_a: assert property ( // R11
    !pm_en |=> (irq_status & ~$past(irq_status)) == IRQ_RESET)
    else $error("interval event while monitor disabled");

  cfg_write_a: assert property ( // R11
    bus_wr && bus_idx == IDX_GLOBAL_CFG |=> global_cfg == $past(wb_dat_i[7:0]))
    else $error("global configuration write lost");

  tick_edge_a: assert property ( // R12
    tick_rise_s ##1 one_second_tick_i |-> ##1 boundary)
    else $error("tick edge did not mark a boundary");

  boundary_pulse_a: assert property (boundary |=> !boundary) // R12
    else $error("boundary lasted more than one cycle");

  slip_hold_a: assert property ( // R13
    slip_i.transmit_buffer_slip |=> cond[BIT_TX_SLIP] [*8])
    else $error("transmit slip indication not held");

  rx_slip_hold_a: assert property ( // R13
    slip_i.receive_buffer_slip |=> cond[BIT_RX_SLIP] [*8])
    else $error("receive slip indication not held");

  tx_slip_end_a: assert property ( // R13
    slip_cnt[1] == SLIP_ONE && !slip_i.transmit_buffer_slip |=> !cond[BIT_TX_SLIP])
    else $error("transmit slip indication outlasted its hold");

  rx_slip_end_a: assert property ( // R13
    slip_cnt[0] == SLIP_ONE && !slip_i.receive_buffer_slip |=> !cond[BIT_RX_SLIP])
    else $error("receive slip indication outlasted its hold");

  result_hold_a: assert property ( // R14
    !boundary && pm_en |=> $stable(occ_flags) && $stable(pers_flags))
    else $error("flags changed between boundaries");

  seen_acc_a: assert property ( // R14
    pm_en && !boundary |=> (seen_acc & $past(cond)) == $past(cond))
    else $error("active condition not accumulated");

  irq_level_a: assert property (irq_o == (|(irq_status & irq_mask)))
    else $error("interrupt level differs from unmasked status");

  irq_boundary_a: assert property (cap_s |=> irq_status[IRQ_BOUNDARY])
    else $error("boundary event not latched");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");

  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");

endmodule : one_second_alarm_monitor

// ### alarm_mon_pkg.sv
// Constants and carriers for the one-second alarm monitor
package alarm_mon_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_GLOBAL_CFG = 10'h006;
  localparam logic [9:0] IDX_OCCURRENCE = 10'h112;
  localparam logic [9:0] IDX_PERSISTENT = 10'h113;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h114;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h115;

  // Global configuration fields
  localparam int         CFG_PM_EN_BIT = 3;
  localparam logic [7:0] CFG_RESET     = 8'h00;

  // Condition positions, shared by both flag registers
  localparam int BIT_LOS     = 7;
  localparam int BIT_AIS     = 6;
  localparam int BIT_OOF     = 5;
  localparam int BIT_RAI     = 4;
  localparam int BIT_REALIGN = 3;
  localparam int BIT_MF_LOSS = 2;
  localparam int BIT_TX_SLIP = 1;
  localparam int BIT_RX_SLIP = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Interrupt event positions
  localparam int         IRQ_W          = 2;
  localparam int         IRQ_BOUNDARY   = 0;
  localparam int         IRQ_ANY_SEEN   = 1;
  localparam logic [1:0] IRQ_RESET      = 2'h0;

  // Slip indication hold time
  localparam longint CLK_HZ        = 25_000_000;
  localparam longint SLIP_HOLD_US  = 125;
  localparam int     SLIP_HOLD_CYC =
    int'((SLIP_HOLD_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);

  // Alarm levels from the detectors
  typedef struct packed {
    logic signal_loss;
    logic alarm_signal;
    logic frame_loss;
    logic remote_alarm;
    logic frame_alignment_change;
    logic multiframe_alignment_lost;
  } alarm_lv_t;

  // One-cycle slip execution pulses
  typedef struct packed {
    logic transmit_buffer_slip;
    logic receive_buffer_slip;
  } slip_ev_t;

endpackage : alarm_mon_pkg

// ### one_second_alarm_monitor_tb_top.sv
// Self-checking bench for the one-second alarm monitor
`timescale 1ns/1ps
module one_second_alarm_monitor_tb_top;
  import alarm_mon_pkg::*;

  logic        core_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic        wb_cyc     = 1'b0;
  logic        wb_stb     = 1'b0;
  logic        wb_we      = 1'b0;
  logic [11:0] wb_adr     = 12'h000;
  logic [3:0]  wb_sel     = 4'h0;
  logic [31:0] wb_wdat    = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  alarm_lv_t   alarm      = '0;
  slip_ev_t    slip       = '0;
  logic        tick_pin   = 1'b0;
  logic        irq_o;
  logic [32:0] notes[$];
  logic [32:0] note;
  logic [9:0]  regs[6];
  logic [5:0]  p;
  logic [1:0]  s;
  logic [7:0]  fl;
  int          miscompares = 0;
  int          compares    = 0;
  int          k;

  always #20 core_clk_i = ~core_clk_i;

  one_second_alarm_monitor one_second_alarm_monitor_i (
    .core_clk_i        (core_clk_i),
    .resetn_i          (resetn_i),
    .wb_cyc_i          (wb_cyc),
    .wb_stb_i          (wb_stb),
    .wb_we_i           (wb_we),
    .wb_adr_i          (wb_adr),
    .wb_sel_i          (wb_sel),
    .wb_dat_i          (wb_wdat),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .alarm_i           (alarm),
    .slip_i            (slip),
    .one_second_tick_i (tick_pin),
    .irq_o             (irq_o)
  );

  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic single cycle; the expected read value is noted before the request
  task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d,
                    input logic [3:0] sel, input logic chk, input logic [31:0] exp);
    int n;
    notes.push_back({chk, exp});
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= sel;
    wb_wdat <= d;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge core_clk_i);
  endtask : wb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d, 4'hF, 1'b0, 32'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0, 4'hF, 1'b1, exp);
  endtask : rd

  task automatic tick(input int gap);
    repeat (gap) @(posedge core_clk_i);
    tick_pin <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    tick_pin <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : tick

  task automatic flags(input logic [7:0] occ, input logic [7:0] per);
    rd(IDX_OCCURRENCE, {24'h0, occ});
    rd(IDX_PERSISTENT, {24'h0, per});
  endtask : flags

  // Each ack pops the oldest note; read data is compared with it when the note asks for a check
  always @(posedge core_clk_i) begin
    if (wb_ack_o === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("BAD t=%0t unexpected ack", $time);
      end else begin
        note = notes.pop_front();
        if (note[32]) begin
          check(wb_dat_o, note[31:0]);
        end
      end
    end
  end

  initial begin
    void'($urandom(58465));
    regs = '{IDX_GLOBAL_CFG, IDX_OCCURRENCE, IDX_PERSISTENT,
             IDX_IRQ_STATUS, IDX_IRQ_MASK, 10'h0FF};
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    for (k = 0; k < 6; k++) begin
      rd(regs[k], 32'h0);
    end
    wr(IDX_GLOBAL_CFG, 32'h5C);
    wb(1'b1, IDX_GLOBAL_CFG, 32'h0, 4'hE, 1'b0, 32'h0);
    wr(10'h0FF, 32'hFF);
    rd(IDX_GLOBAL_CFG, 32'h5C);
    rd(10'h0FF, 32'h0);
    // An interval with no condition at all flags nothing
    tick(20);
    flags(8'h00, 8'h00);
    p = 6'($urandom_range(1, 63));
    s = 2'($urandom_range(1, 3));
    fl = {p, s};
    alarm <= alarm_lv_t'(p);
    slip  <= slip_ev_t'(s);
    @(posedge core_clk_i);
    slip <= '0;
    // Conditions rose inside the second interval, so nothing persists yet
    tick(20);
    flags(fl, 8'h00);
    wr(IDX_OCCURRENCE, 32'hFF);
    rd(IDX_OCCURRENCE, {24'h0, fl});
    // Still active with no new rise; slips still inside their hold time
    tick(100);
    flags(fl, fl);
    alarm <= '0;
    // Slips expire mid-interval; seen but no longer active at the boundary
    tick(3200);
    flags(fl, 8'h00);
    rd(IDX_IRQ_STATUS, 32'h3);
    check({31'h0, irq_o}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk_i);
    check({31'h0, irq_o}, 32'h1);
    wr(IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge core_clk_i);
    check({31'h0, irq_o}, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h2);
    // Disabling clears the flags and stops boundary events
    wr(IDX_GLOBAL_CFG, 32'h0);
    flags(8'h00, 8'h00);
    alarm <= alarm_lv_t'(p);
    tick(20);
    flags(8'h00, 8'h00);
    rd(IDX_IRQ_STATUS, 32'h2);
    summarize();
  end
endmodule : one_second_alarm_monitor_tb_top
